// *** rtl/spo_status_pin.sv ***
// Purpose: Status output pin selection, shaping and pin status readback.
// Assumes: Status sources come from logic on clock_in; pins are asynchronous.
// Notes: Registers are reached through a simple word port of this block.
//        Reserved selector codes drive a quiet low, which the invert bit may flip.
//        Readback shows the registered shaped value even while the pad is released.
//        The bond pad and all pins pass a two-stage synchroniser before use.
//
// How it works
// - A five-bit selector picks the pin source; 0x1D low, 0x1E high, others reserved.
// - Code 0x0 outputs PLL lock, 0x2 reference loss, 0x4 crystal loss.
// - Code 0x5 outputs reference activity, 0x7 reference unusable.
// - Code 0x9 outputs the OR of interrupt flags ANDed with the mask.
// - Code 0xA outputs device ready once startup has completed.
// - Invert bit clear passes the selected signal; set outputs its inverse.
// - Invert bit has no effect while selector holds 0x1F.
// - Open-drain, invert clear: value 0 pulls low, value 1 releases.
// - Open-drain, invert set: value 1 pulls low, value 0 releases.
// - Tristate bit set puts the pin driver in high impedance.
// - Pulldown bit enables the pulldown; software avoids it with open-drain.
// - Pullup bit enables the pullup and resets to one.
// - Startup register shows the die bond option, read only.
// - Pin levels latched at startup: status, data, clock, enable; bits 4-5 zero.
// - Status readback shows the driven pin value for selector 0x0-0x4, else zero.
// - Enable readback shows the enable pin unless bypass is set, then zero.
// - With bypass clear, enable pin low disables clock outputs, except SPI mode.
`timescale 1ns/100ps
module spo_status_pin #(
    parameter int unsigned INT_W = spo_pkg::SPO_INT_W
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,

    // Register port
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [spo_pkg::SPO_ADDR_W-1:0] reg_addr_in,
    input wire logic [spo_pkg::SPO_DATA_W-1:0] reg_wdata_in,
    output logic [spo_pkg::SPO_DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,

    // Internal status sources
    input wire spo_pkg::spo_sources_t sources_in,
    input wire logic [INT_W-1:0] interrupt_flags_in,
    input wire logic [INT_W-1:0] interrupt_mask_in,
    input wire logic die_bond_option_in,

    // Enable pin control
    input wire logic enable_pin_bypass_in,
    input wire logic spi_mode_in,
    output logic clock_outputs_enable_out,

    // Asynchronous pin levels
    input wire spo_pkg::spo_pins_t pins_in,

    // Status pin pad
    output logic status_pin_out,
    output logic status_pin_oe_out,
    output logic status_pin_pullup_en_out,
    output logic status_pin_pulldown_en_out
);
    import spo_pkg::*;

    // Configuration register
    logic [SPO_DATA_W-1:0] config_q;
    logic [SPO_DATA_W-1:0] config_d;

    // Startup snapshot
    logic [SPO_SNAP_USED_PINS-1:0] pins_latched_at_powerup_q;
    logic die_bond_option_q;
    logic [1:0] settle_cnt_q;
    logic [1:0] settle_cnt_d;
    logic snapshot_taken_q;

    // Pin output state
    logic status_value_q;
    logic status_value_d;
    spo_pad_ctrl_t pad_q;
    spo_pad_ctrl_t pad_d;

    // Read path
    logic [SPO_DATA_W-1:0] rdata_q;
    logic [SPO_DATA_W-1:0] rdata_d;
    logic rvalid_q;

    // Synchronised pins
    spo_pins_t pins_sync;
    logic die_bond_option_sync;

    // Decoded configuration fields
    logic [SPO_SEL_W-1:0] status_pin_source_sel;
    logic status_pin_invert;
    logic status_pin_pullup_en;
    logic status_pin_pulldown_en;
    logic status_pin_tristate;
    logic status_pin_open_drain_en;

    // Selection wires
    logic [INT_W-1:0] masked_flags;
    logic device_interrupt;
    logic selected_value;
    logic invert_applies;
    logic shaped_value;
    logic readback_window;
    logic status_readback;
    logic enable_pin_level;
    logic enable_readback;

    // Register decode
    logic hit_config;
    logic hit_snapshot;
    logic hit_live;
    logic config_write;
    logic snapshot_capture;

    // Startup and live snapshot words
    logic [SPO_DATA_W-1:0] snapshot_word;
    logic [SPO_DATA_W-1:0] live_word;

    spo_sync #(
        .WIDTH(SPO_SNAP_USED_PINS)
    ) u_pin_sync (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .async_in(pins_in),
        .sync_out(pins_sync)
    );

    // Bond pad is a die level from outside the clock domain
    spo_sync #(
        .WIDTH(1)
    ) u_bond_sync (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .async_in(die_bond_option_in),
        .sync_out(die_bond_option_sync)
    );

    // Field decode
    assign status_pin_source_sel = config_q[SPO_SEL_LSB +: SPO_SEL_W];
    assign status_pin_invert = config_q[SPO_INVERT_BIT];
    assign status_pin_pullup_en = config_q[SPO_PULLUP_BIT];
    assign status_pin_pulldown_en = config_q[SPO_PULLDOWN_BIT];
    assign status_pin_tristate = config_q[SPO_TRISTATE_BIT];
    assign status_pin_open_drain_en = config_q[SPO_OPEN_DRAIN_BIT];

    // Source selection
    for (genvar i = 0; i < INT_W; i++) begin : g_int_mask
        assign masked_flags[i] = interrupt_flags_in[i] & interrupt_mask_in[i];
    end
    assign device_interrupt = |masked_flags;

    always_comb begin
        case (status_pin_source_sel)
            SPO_SEL_PLL_LOCK: begin
                selected_value = sources_in.pll_locked;
            end
            SPO_SEL_REF_LOSS: begin
                selected_value = sources_in.reference_signal_loss_monitor;
            end
            SPO_SEL_XTAL_LOSS: begin
                selected_value = sources_in.crystal_signal_loss_monitor;
            end
            SPO_SEL_REF_ACTIVITY: begin
                selected_value = sources_in.reference_activity_monitor;
            end
            SPO_SEL_REF_INVALID: begin
                selected_value = sources_in.reference_invalid;
            end
            SPO_SEL_INTERRUPT: begin
                selected_value = device_interrupt;
            end
            SPO_SEL_READY: begin
                selected_value = sources_in.startup_done;
            end
            SPO_SEL_CONST_LOW: begin
                selected_value = 1'b0;
            end
            SPO_SEL_CONST_HIGH: begin
                selected_value = 1'b1;
            end
            default: begin
                // Reserved codes carry a quiet low
                selected_value = 1'b0;
            end
        endcase
    end

    // Polarity
    // The no-invert code keeps its low level whatever the invert bit holds
    assign invert_applies =
        status_pin_invert && (status_pin_source_sel != SPO_SEL_NO_INVERT);
    assign shaped_value = selected_value ^ invert_applies;
    assign status_value_d = shaped_value;

    // Pad drive: push-pull drives the value; open-drain only pulls low on a zero
    // Tristate wins over open drain; pulls stay as configured in every mode
    always_comb begin
        pad_d = '0;
        pad_d.pullup_en = status_pin_pullup_en;
        pad_d.pulldown_en = status_pin_pulldown_en;
        if (status_pin_tristate) begin
            pad_d.drive_en = 1'b0;
            pad_d.drive_value = 1'b0;
        end else if (status_pin_open_drain_en) begin
            // Inverted value already folded in, so a zero here means pull low
            pad_d.drive_en = ~shaped_value;
            pad_d.drive_value = 1'b0;
        end else begin
            pad_d.drive_en = 1'b1;
            pad_d.drive_value = shaped_value;
        end
    end

    // Readback of pins
    assign readback_window = (status_pin_source_sel <= SPO_SEL_READBACK_MAX);
    assign status_readback = readback_window & status_value_q;
    // Enable level is read only after the pin synchroniser
    assign enable_pin_level = pins_sync.enable_or_chip_select_pin;
    assign enable_readback = ~enable_pin_bypass_in & enable_pin_level;

    // Clock output enable
    // Enable pin is taken as active high; bypass or SPI mode keeps outputs on
    assign clock_outputs_enable_out =
        enable_pin_bypass_in | spi_mode_in | enable_pin_level;

    // Register decode
    assign hit_config = (reg_addr_in == SPO_IDX_PIN_CONFIG);
    assign hit_snapshot = (reg_addr_in == SPO_IDX_STARTUP_SNAPSHOT);
    assign hit_live = (reg_addr_in == SPO_IDX_LIVE_STATUS);
    assign config_write = reg_wr_en_in & hit_config;

    // Writes reach only the writable fields of the configuration register
    assign config_d = config_write ?
        (reg_wdata_in & SPO_CONFIG_WR_MASK) : config_q;

    // Startup capture waits for the synchronisers to settle, then fires once
    assign snapshot_capture = ~snapshot_taken_q && (settle_cnt_q == SPO_SETTLE_CYCLES);
    assign settle_cnt_d = (settle_cnt_q == SPO_SETTLE_CYCLES) ?
        settle_cnt_q : settle_cnt_q + 2'h1;

    // Snapshot word: used pins, bond option, everything else reads zero
    for (genvar b = 0; b < SPO_DATA_W; b++) begin : g_snap_bit
        if (b < SPO_SNAP_USED_PINS) begin : g_pin
            assign snapshot_word[b] = pins_latched_at_powerup_q[b];
        end else if (b == SPO_SNAP_BOND_BIT) begin : g_bond
            assign snapshot_word[b] = die_bond_option_q;
        end else begin : g_zero
            assign snapshot_word[b] = 1'b0;
        end
    end

    always_comb begin
        live_word = '0;
        live_word[SPO_LIVE_ENABLE_BIT] = enable_readback;
        live_word[SPO_LIVE_STATUS_BIT] = status_readback;
    end

    // Read mux; unmapped indices answer zero
    // A write and a read in one cycle return the old configuration
    always_comb begin
        rdata_d = '0;
        if (hit_config) begin
            rdata_d = config_q;
        end else if (hit_snapshot) begin
            rdata_d = snapshot_word;
        end else if (hit_live) begin
            rdata_d = live_word;
        end
    end

    // Configuration state
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            config_q <= SPO_CONFIG_RESET;
        end else begin
            config_q <= config_d;
        end
    end

    // Settle counter, saturates once the synchronisers have filled
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            settle_cnt_q <= '0;
        end else begin
            settle_cnt_q <= settle_cnt_d;
        end
    end

    // Startup snapshot, taken once per reset
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            snapshot_taken_q <= 1'b0;
            pins_latched_at_powerup_q <= '0;
            die_bond_option_q <= 1'b0;
        end else if (snapshot_capture) begin
            snapshot_taken_q <= 1'b1;
            pins_latched_at_powerup_q <= pins_sync;
            die_bond_option_q <= die_bond_option_sync;
        end
    end

    // Registered pin value, also the source of the readback bit
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_value_q <= 1'b0;
        end else begin
            status_value_q <= status_value_d;
        end
    end

    // Registered pad controls; the pad stays released while reset is held
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pad_q <= '0;
        end else begin
            pad_q <= pad_d;
        end
    end

    // Read valid, one cycle after the request
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_en_in;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= '0;
        end else if (reg_rd_en_in) begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign status_pin_out = pad_q.drive_value;
    assign status_pin_oe_out = pad_q.drive_en;
    assign status_pin_pullup_en_out = pad_q.pullup_en;
    assign status_pin_pulldown_en_out = pad_q.pulldown_en;

endmodule : spo_status_pin

// *** shared/spo_pkg.sv ***
// Purpose: Shared constants and types for the status pin output block.
// Assumes: One system clock; register access over a simple word port.
// Notes: Register indices are local to this block.
package spo_pkg;

    // Register port geometry
    localparam int unsigned SPO_ADDR_W = 4;
    localparam int unsigned SPO_DATA_W = 16;

    // Register indices
    localparam logic [3:0] SPO_IDX_PIN_CONFIG = 4'h0;
    localparam logic [3:0] SPO_IDX_STARTUP_SNAPSHOT = 4'h1;
    localparam logic [3:0] SPO_IDX_LIVE_STATUS = 4'h2;

    // Configuration register fields
    localparam int unsigned SPO_SEL_LSB = 0;
    localparam int unsigned SPO_SEL_W = 5;
    localparam int unsigned SPO_INVERT_BIT = 8;
    localparam int unsigned SPO_PULLUP_BIT = 9;
    localparam int unsigned SPO_PULLDOWN_BIT = 10;
    localparam int unsigned SPO_TRISTATE_BIT = 11;
    localparam int unsigned SPO_OPEN_DRAIN_BIT = 12;
    localparam logic [15:0] SPO_CONFIG_RESET = 16'h0200;
    localparam logic [15:0] SPO_CONFIG_WR_MASK = 16'h1f1f;

    // Startup snapshot fields
    localparam int unsigned SPO_SNAP_PINS_W = 6;
    localparam int unsigned SPO_SNAP_BOND_BIT = 7;
    localparam int unsigned SPO_SNAP_USED_PINS = 4;

    // Live status fields
    localparam int unsigned SPO_LIVE_ENABLE_BIT = 0;
    localparam int unsigned SPO_LIVE_STATUS_BIT = 1;

    // Source selector codes
    localparam logic [4:0] SPO_SEL_PLL_LOCK = 5'h00;
    localparam logic [4:0] SPO_SEL_REF_LOSS = 5'h02;
    localparam logic [4:0] SPO_SEL_XTAL_LOSS = 5'h04;
    localparam logic [4:0] SPO_SEL_REF_ACTIVITY = 5'h05;
    localparam logic [4:0] SPO_SEL_REF_INVALID = 5'h07;
    localparam logic [4:0] SPO_SEL_INTERRUPT = 5'h09;
    localparam logic [4:0] SPO_SEL_READY = 5'h0a;
    localparam logic [4:0] SPO_SEL_CONST_LOW = 5'h1d;
    localparam logic [4:0] SPO_SEL_CONST_HIGH = 5'h1e;
    localparam logic [4:0] SPO_SEL_NO_INVERT = 5'h1f;
    localparam logic [4:0] SPO_SEL_READBACK_MAX = 5'h04;

    // Cycles for the pin synchronisers to settle before the startup capture
    localparam logic [1:0] SPO_SETTLE_CYCLES = 2'h2;

    // Default interrupt vector width
    localparam int unsigned SPO_INT_W = 8;

    // Internal status sources, all on the system clock
    typedef struct packed {
        logic pll_locked;
        logic reference_signal_loss_monitor;
        logic crystal_signal_loss_monitor;
        logic reference_activity_monitor;
        logic reference_invalid;
        logic startup_done;
    } spo_sources_t;

    // Drive controls for the status pin pad
    typedef struct packed {
        logic drive_value;
        logic drive_en;
        logic pullup_en;
        logic pulldown_en;
    } spo_pad_ctrl_t;

    // Asynchronous pins sampled by the block
    typedef struct packed {
        logic enable_or_chip_select_pin;
        logic serial_clock_pin;
        logic serial_data_pin;
        logic status_pin;
    } spo_pins_t;

endpackage : spo_pkg

// *** rtl/spo_sync.sv ***
// Purpose: Two-stage synchroniser for a group of asynchronous levels.
// Assumes: Inputs are slow levels; no bus coherency is needed across bits.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/100ps
module spo_sync #(
    parameter int unsigned WIDTH = 4
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;
endmodule : spo_sync

// *** test/spo_properties.sv ***
// Purpose: Port assertions for the status pin block.
// Assumes: Config writes reach the pad two edges after the strobe.
// Notes: Bound from the testbench top file.
`timescale 1ns/100ps
module spo_properties (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rvalid_out,
    // Enable control and pad
    input wire logic enable_pin_bypass_in,
    input wire logic spi_mode_in,
    input wire logic clock_outputs_enable_out,
    input wire logic status_pin_out,
    input wire logic status_pin_oe_out,
    input wire logic status_pin_pullup_en_out,
    input wire logic status_pin_pulldown_en_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);
    logic cfg_wr;
    logic [12:0] wv;
    assign cfg_wr = reg_wr_en_in && (reg_addr_in == 4'h0);
    assign wv = reg_wdata_in[12:0];

    chk_read_answer: assert property (reg_rd_en_in |=> reg_rvalid_out)
        else $error("read strobe gave no valid");
    chk_valid_lone: assert property (!reg_rd_en_in |=> !reg_rvalid_out)
        else $error("valid without read strobe");
    chk_const_low: assert property (cfg_wr && wv == 13'h001d |-> ##2
        status_pin_oe_out && !status_pin_out) else $error("constant low not driven");
    chk_const_high: assert property (cfg_wr && wv == 13'h001e |-> ##2
        status_pin_oe_out && status_pin_out) else $error("constant high not driven");
    chk_invert_high: assert property (cfg_wr && wv == 13'h011e |-> ##2
        !status_pin_out) else $error("invert not applied");
    chk_no_invert: assert property (cfg_wr && wv == 13'h011f |-> ##2
        !status_pin_out) else $error("invert applied on 0x1f");
    chk_od_release: assert property (cfg_wr && wv == 13'h101e |-> ##2
        !status_pin_oe_out) else $error("open drain did not release");
    chk_od_pull_low: assert property (cfg_wr && wv == 13'h111e |-> ##2
        status_pin_oe_out && !status_pin_out) else $error("open drain did not pull low");
    chk_tristate_off: assert property (cfg_wr && reg_wdata_in[11] |-> ##2
        !status_pin_oe_out) else $error("tristate still driving");
    chk_pull_follow: assert property (cfg_wr |-> ##2
        status_pin_pullup_en_out == $past(reg_wdata_in[9], 2) &&
        status_pin_pulldown_en_out == $past(reg_wdata_in[10], 2))
        else $error("pull enables do not follow config");
    chk_clk_bypass: assert property (enable_pin_bypass_in || spi_mode_in |->
        clock_outputs_enable_out) else $error("clock outputs gated in bypass");
endmodule : spo_properties

// *** test/spo_board_model.sv ***
// Purpose: Board around the status pin: pulls, idle serial bus, enable pin.
// Assumes: A board pull-up on the status line.
// Notes: An internal pull beats the board resistor.
`timescale 1ns/100ps
module spo_board_model #(
    parameter logic EXT_PULL = 1'b1
) (
    // Pad from the block
    input wire logic pad_value_in,
    input wire logic pad_oe_in,
    input wire logic pullup_en_in,
    input wire logic pulldown_en_in,
    // Board side
    input wire logic enable_level_in,
    output spo_pkg::spo_pins_t pins_out,
    output logic status_wire_out
);
    // Released pad falls to whichever pull is active
    assign status_wire_out = pad_oe_in ? pad_value_in :
        (pullup_en_in ? 1'b1 : (pulldown_en_in ? 1'b0 : EXT_PULL));
    // Serial bus idles high through its pull-ups
    assign pins_out = {enable_level_in, 1'b1, 1'b1, status_wire_out};
endmodule : spo_board_model

// *** test/spo_status_pin_test.sv ***
// Purpose: Self-checking bench for the status pin block.
// Assumes: Inputs change on the falling edge.
// Notes: Board model resolves the status line.
`timescale 1ns/100ps
module spo_status_pin_test;
    import spo_pkg::*;
    logic clock_in, reset_n_in, wr_en, rd_en, bypass, spi, en_pin, bond;
    logic rvalid, clk_oe, pad_val, pad_oe, pu, pd, wire_lvl;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic [7:0] flags, mask;
    spo_sources_t src;
    spo_pins_t pins;
    int err_total, samples_checked;
    int cycles = 0;
    logic [4:0] codes [9] = '{5'h00, 5'h02, 5'h04, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h1d, 5'h1e};
    logic [5:0] srcs [9] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h00, 6'h01, 6'h3f, 6'h00};
    logic exp_v [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

    spo_status_pin dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .sources_in(src), .interrupt_flags_in(flags), .interrupt_mask_in(mask),
        .die_bond_option_in(bond), .enable_pin_bypass_in(bypass), .spi_mode_in(spi),
        .clock_outputs_enable_out(clk_oe), .pins_in(pins), .status_pin_out(pad_val),
        .status_pin_oe_out(pad_oe), .status_pin_pullup_en_out(pu),
        .status_pin_pulldown_en_out(pd));
    spo_board_model board (.pad_value_in(pad_val), .pad_oe_in(pad_oe),
        .pullup_en_in(pu), .pulldown_en_in(pd), .enable_level_in(en_pin),
        .pins_out(pins), .status_wire_out(wire_lvl));

    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] got);
        samples_checked++;
        if (got !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clock_in);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clock_in);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(negedge clock_in);
        rd_en = 1'b1;
        addr = a;
        @(negedge clock_in);
        rd_en = 1'b0;
        check("rvalid", 16'h0001, {15'h0, rvalid});
        check("rdata", e, rdata);
    endtask : rd
    // Expected pad as {oe, value, pullup, pulldown}
    task automatic pad(input logic [3:0] e);
        @(posedge clock_in);
        #1;
        check("pad", {12'h0, e}, {12'h0, pad_oe, pad_val, pu, pd});
    endtask : pad
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        reset_n_in = 1'b0;
        {wr_en, rd_en, bypass, spi} = 4'h0;
        {en_pin, bond} = 2'b11;
        addr = 4'h0;
        wdata = 16'h0;
        src = spo_sources_t'(6'h20);
        flags = 8'h10;
        mask = 8'h00;
        err_total = 0;
        samples_checked = 0;
        repeat (4) @(negedge clock_in);
        reset_n_in = 1'b1;
        pad(4'he);
        rd(SPO_IDX_PIN_CONFIG, 16'h0200);
        for (int i = 0; i < 9; i++) begin
            @(negedge clock_in);
            src = spo_sources_t'(srcs[i]);
            mask = (codes[i] == SPO_SEL_INTERRUPT) ? 8'h10 : 8'h00;
            wr(SPO_IDX_PIN_CONFIG, {11'h000, codes[i]});
            pad({1'b1, exp_v[i], 2'b00});
            rd(SPO_IDX_LIVE_STATUS, {14'h0, codes[i] <= 5'h04 && exp_v[i], 1'b1});
            wr(SPO_IDX_PIN_CONFIG, {11'h008, codes[i]});
            pad({1'b1, !exp_v[i], 2'b00});
        end
        @(negedge clock_in);
        mask = 8'h0f;
        wr(SPO_IDX_PIN_CONFIG, 16'h0009);
        pad(4'h8);
        wr(SPO_IDX_PIN_CONFIG, 16'h011f);
        pad(4'h8);
        wr(SPO_IDX_PIN_CONFIG, 16'h101e);
        pad(4'h0);
        check("wire", 16'h0001, {15'h0, wire_lvl});
        wr(SPO_IDX_PIN_CONFIG, 16'h111e);
        pad(4'h8);
        wr(SPO_IDX_PIN_CONFIG, 16'h0c1e);
        pad(4'h1);
        check("wire", 16'h0000, {15'h0, wire_lvl});
        wr(SPO_IDX_STARTUP_SNAPSHOT, 16'hffff);
        wr(SPO_IDX_LIVE_STATUS, 16'hffff);
        wr(SPO_IDX_PIN_CONFIG, 16'hffff);
        rd(SPO_IDX_PIN_CONFIG, 16'h1f1f);
        rd(SPO_IDX_STARTUP_SNAPSHOT, 16'h008f);
        rd(SPO_IDX_LIVE_STATUS, 16'h0001);
        rd(4'hf, 16'h0000);
        @(negedge clock_in);
        en_pin = 1'b0;
        repeat (3) @(negedge clock_in);
        check("clk_oe", 16'h0000, {15'h0, clk_oe});
        rd(SPO_IDX_LIVE_STATUS, 16'h0000);
        @(negedge clock_in);
        spi = 1'b1;
        #1;
        check("clk_oe", 16'h0001, {15'h0, clk_oe});
        @(negedge clock_in);
        {spi, bypass, en_pin} = 3'b011;
        #1;
        check("clk_oe", 16'h0001, {15'h0, clk_oe});
        repeat (3) @(negedge clock_in);
        rd(SPO_IDX_LIVE_STATUS, 16'h0000);
        complete_run();
    end
endmodule : spo_status_pin_test

bind spo_status_pin spo_properties chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rvalid_out(reg_rvalid_out),
    .enable_pin_bypass_in(enable_pin_bypass_in), .spi_mode_in(spi_mode_in),
    .clock_outputs_enable_out(clock_outputs_enable_out), .status_pin_out(status_pin_out),
    .status_pin_oe_out(status_pin_oe_out), .status_pin_pullup_en_out(status_pin_pullup_en_out),
    .status_pin_pulldown_en_out(status_pin_pulldown_en_out));
